// *** dv/asram_host_assertions.sv ***
`timescale 1ns/100ps
module asram_host_assertions
    import asram_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_ready,
    input wire logic [LANES-1:0] req_lane_en,
    input wire logic rsp_valid,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic chip_sel_n,
    input wire logic write_strobe_n,
    input wire logic out_drive_en_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic mem_data_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // pin protocol and read response
    // ------------------------------------------------------------
    property p_wr; !write_strobe_n |-> !chip_sel_n && mem_data_oe && out_drive_en_n; endproperty
    a_wr: assert property (p_wr) else $error("write strobe unqualified");
    property p_rd; !out_drive_en_n |-> !chip_sel_n && write_strobe_n && !mem_data_oe; endproperty
    a_rd: assert property (p_rd) else $error("read with host driving");
    property p_lane; !chip_sel_n |-> !(upper_byte_sel_n && lower_byte_sel_n); endproperty
    a_lane: assert property (p_lane) else $error("select without lane");
    property p_addr; !chip_sel_n && $past(!chip_sel_n) |-> $stable(mem_addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved in access");
    property p_wlen; $fell(write_strobe_n) |-> !write_strobe_n [*3]; endproperty
    a_wlen: assert property (p_wlen) else $error("write pulse short");
    property p_wdat; !write_strobe_n && $past(!write_strobe_n) |-> $stable(mem_data_out); endproperty
    a_wdat: assert property (p_wdat) else $error("write data moved");
    property p_wend; $rose(write_strobe_n) |-> $rose(chip_sel_n) && mem_data_oe; endproperty
    a_wend: assert property (p_wend) else $error("write end not joint");
    property p_rsp; req_valid && req_ready && !req_write && req_lane_en != 2'h0
        |-> ##[4:12] rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("read response missing");
    c_wr: cover property ($rose(write_strobe_n));
    c_rd: cover property (rsp_valid);
    c_half: cover property (!chip_sel_n && upper_byte_sel_n);
endmodule
bind asram_host asram_host_assertions chk_u (.sys_clk, .nrst, .req_valid, .req_write,
    .req_ready, .req_lane_en, .rsp_valid, .mem_addr, .chip_sel_n, .write_strobe_n,
    .out_drive_en_n, .upper_byte_sel_n, .lower_byte_sel_n, .mem_data_out, .mem_data_oe);

// *** dv/asram_sram_model.sv ***
`timescale 1ns/100ps
module asram_sram_model
    import asram_pkg::*;
(
    input wire logic [ADDR_W-1:0] a,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic ub_n,
    input wire logic lb_n,
    input wire logic [DATA_W-1:0] hd,
    input wire logic hoe,
    output logic [DATA_W-1:0] bd
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] wm, dm;
    logic rd;
    assign wm = {{BYTE_W{!ub_n}}, {BYTE_W{!lb_n}}};
    assign rd = !cs_n && we_n && !oe_n;
    assign dm = rd ? wm : '0;
    // floating lanes read back inverted so a stray sample shows
    assign bd = hoe ? hd : mem[a] ^ ~dm;
    // ------------------------------------------------------------
    // write: what is on the bus as the write ends stays
    // ------------------------------------------------------------
    // explicit list: a star list would wake on every word of the array
    always @(a or cs_n or we_n or wm or hd or hoe)
    begin
        if (!cs_n && !we_n)
        begin
            mem[a] = (mem[a] & ~wm) | ((hoe ? hd : ~hd) & wm);
        end
    end
endmodule

// *** dv/test_asram_host.sv ***
`timescale 1ns/100ps
module test_asram_host
    import asram_pkg::*;
;
    logic sys_clk = 1'h0, nrst = 1'h0, req_valid = 1'h0, req_write = 1'h0;
    logic req_ready, rsp_valid, mem_data_oe, chip_sel_n, write_strobe_n;
    logic out_drive_en_n, upper_byte_sel_n, lower_byte_sel_n;
    logic [ADDR_W-1:0] req_addr = '0, mem_addr;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, mem_data_in, mem_data_out;
    logic [LANES-1:0] req_lane_en = '0;
    logic [DATA_W-1:0] shadow [8];
    logic [ADDR_W-1:0] pool [8];
    logic [31:0] seed = 32'h8F76E591;
    int n_mismatch = 0, check_count = 0;
    asram_host dut_u (.sys_clk, .nrst, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_lane_en, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .chip_sel_n,
        .write_strobe_n, .out_drive_en_n, .upper_byte_sel_n, .lower_byte_sel_n,
        .mem_data_in, .mem_data_out, .mem_data_oe);
    asram_sram_model mdl_u (.a(mem_addr), .cs_n(chip_sel_n), .we_n(write_strobe_n),
        .oe_n(out_drive_en_n), .ub_n(upper_byte_sel_n), .lb_n(lower_byte_sel_n),
        .hd(mem_data_out), .hoe(mem_data_oe), .bd(mem_data_in));
    initial forever #12.5 sys_clk = ~sys_clk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] ln);
        return {{BYTE_W{ln[HI_LANE]}}, {BYTE_W{ln[LO_LANE]}}};
    endfunction
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one request, held until taken; zero lanes must give no response
    task automatic xfer(input logic w, input int k, input logic [DATA_W-1:0] d,
        input logic [LANES-1:0] ln);
        logic [DATA_W-1:0] m;
        int i;
        m = lane_mask(ln);
        @(negedge sys_clk);
        {req_valid, req_write, req_addr, req_wdata, req_lane_en} = {1'h1, w, pool[k], d, ln};
        for (i = 0; i < 40 && req_ready !== 1'h1; i++) @(negedge sys_clk);
        chk(DATA_W'(req_ready === 1'h1), DATA_W'(1'h1));
        @(negedge sys_clk);
        req_valid = 1'h0;
        if (w)
            shadow[k] = (shadow[k] & ~m) | (d & m);
        for (i = 0; i < 16 && rsp_valid !== 1'h1; i++) @(negedge sys_clk);
        chk(DATA_W'(rsp_valid), DATA_W'(!w && ln != 2'h0));
        if (rsp_valid === 1'h1)
            chk(rsp_rdata, shadow[k] & m);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        #(CLK_PERIOD_NS * 10000);
        n_mismatch++;
        end_sim;
    end
    initial
    begin
        int k;
        repeat (20) @(negedge sys_clk);
        chk(DATA_W'({chip_sel_n, write_strobe_n, out_drive_en_n, req_ready}), DATA_W'(4'hE));
        nrst = 1'h1;
        for (k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            pool[k] = (k == 0) ? '0 : (k == 7) ? '1 : seed[ADDR_W-1:0];
            xfer(1'h1, k, seed[31:16], 2'h3);
        end
        $display("fill done");
        for (k = 0; k < 8; k++)
            xfer(1'h0, k, '0, 2'h3);
        $display("readback done");
        for (k = 0; k < 16; k++)
            xfer(!k[0], 7, 16'hA55A ^ DATA_W'(k), k[2:1] ^ {2{k[0]}});
        $display("lanes done");
        repeat (60)
        begin
            seed = lfsr(seed);
            xfer(seed[0], int'(seed[3:1]), seed[31:16], seed[5:4]);
        end
        $display("random done");
        end_sim;
    end
endmodule

// *** hw/asram_cycle_timer.sv ***
`timescale 1ns/100ps
module asram_cycle_timer
    import asram_pkg::*;
#(
    parameter int WIDTH = CNT_W
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    output logic done
);
    logic [WIDTH-1:0] cnt_q;

    if (WIDTH < 2)
    begin
        $error("asram_cycle_timer: WIDTH too small");
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
        end
        else if (load)
        begin
            cnt_q <= load_val;
        end
        else if (cnt_q != '0)
        begin
            cnt_q <= cnt_q - 1'h1;
        end
    end

    // not gated by load: the sequencer reloads on done, a gate would loop
    assign done = (cnt_q == '0);
endmodule

// *** hw/asram_host.sv ***
`timescale 1ns/100ps
// Function
// - write with chip select and write strobe low, lanes by byte selects.
// - read with chip select, output enable low, write strobe high.
// - write lasts while strobe, select and a byte select all active.
// - data setup and hold measured from the edge ending the write.
// - host never drives data while the device drives.
// - address valid no later than falling select edge on reads.
module asram_host
    import asram_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [LANES-1:0] req_lane_en,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic [ADDR_W-1:0] mem_addr,
    output logic chip_sel_n,
    output logic write_strobe_n,
    output logic out_drive_en_n,
    output logic upper_byte_sel_n,
    output logic lower_byte_sel_n,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe
);
    typedef enum logic [2:0] {ASRAM_IDLE, ASRAM_RD, ASRAM_WR, ASRAM_WR_END, ASRAM_TURN}
        asram_state_e;

    asram_state_e state_q;
    logic [DATA_W-1:0] din_s1_q;
    logic [DATA_W-1:0] din_s2_q;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic tmr_done;
    logic [LANES-1:0] lane_q;

    if (RD_CYC + 2 >= (1 << CNT_W) || WR_CYC >= (1 << CNT_W))
    begin
        $error("asram_host: timer too narrow for cycle counts");
    end

    // ------------------------------------------------------------
    // data pin synchroniser
    // ------------------------------------------------------------
    // two stages; read data is sampled three cycles after the address is latched, two after the selects fall
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            din_s1_q <= '0;
            din_s2_q <= '0;
        end
        else
        begin
            din_s1_q <= mem_data_in;
            din_s2_q <= din_s1_q;
        end
    end

    asram_cycle_timer #(
        .WIDTH(CNT_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n);
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        tmr_load = 1'h0;
        tmr_val = '0;
        case (state_q)
            ASRAM_IDLE:
            begin
                if (req_valid && req_ready && req_lane_en != '0)
                begin
                    tmr_load = 1'h1;
                    // extra two cycles cover the input synchroniser
                    tmr_val = req_write ? cyc(WR_CYC - 1) : cyc(RD_CYC + 1);
                end
            end
            ASRAM_WR_END, ASRAM_RD:
            begin
                if (tmr_done)
                begin
                    tmr_load = 1'h1;
                    tmr_val = cyc(TURN_CYC - 1);
                end
            end
            default:
            begin
                tmr_load = 1'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_q <= ASRAM_IDLE;
        end
        else
        begin
            case (state_q)
                ASRAM_IDLE:
                begin
                    if (req_valid && req_ready && req_lane_en != '0)
                    begin
                        state_q <= req_write ? ASRAM_WR : ASRAM_RD;
                    end
                end
                ASRAM_WR:
                begin
                    if (tmr_done)
                    begin
                        state_q <= ASRAM_WR_END;
                    end
                end
                ASRAM_WR_END:
                begin
                    state_q <= ASRAM_TURN;
                end
                ASRAM_RD:
                begin
                    if (tmr_done)
                    begin
                        state_q <= ASRAM_TURN;
                    end
                end
                ASRAM_TURN:
                begin
                    if (tmr_done)
                    begin
                        state_q <= ASRAM_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ASRAM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            req_ready <= 1'h0;
        end
        else
        begin
            req_ready <= (state_q == ASRAM_IDLE) && !(req_valid && req_ready)
                || (state_q == ASRAM_TURN && tmr_done);
        end
    end

    // ------------------------------------------------------------
    // address, lanes and write data
    // ------------------------------------------------------------
    // address and lanes latched before any strobe falls, held to cycle end
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            mem_addr <= '0;
            lane_q <= '0;
            mem_data_out <= '0;
        end
        else if (state_q == ASRAM_IDLE && req_valid && req_ready)
        begin
            mem_addr <= req_addr;
            lane_q <= req_lane_en;
            mem_data_out <= req_wdata;
        end
    end

    // ------------------------------------------------------------
    // pin controls
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            chip_sel_n <= 1'h1;
            write_strobe_n <= 1'h1;
            out_drive_en_n <= 1'h1;
            upper_byte_sel_n <= 1'h1;
            lower_byte_sel_n <= 1'h1;
            mem_data_oe <= 1'h0;
        end
        else
        begin
            // selects fall one cycle after address settles
            chip_sel_n <= !(state_q == ASRAM_RD || state_q == ASRAM_WR);
            upper_byte_sel_n <= !((state_q == ASRAM_RD || state_q == ASRAM_WR)
                && lane_q[HI_LANE]);
            lower_byte_sel_n <= !((state_q == ASRAM_RD || state_q == ASRAM_WR)
                && lane_q[LO_LANE]);
            write_strobe_n <= !(state_q == ASRAM_WR);
            // output enable held high for writes keeps device off the bus
            out_drive_en_n <= !(state_q == ASRAM_RD);
            // data driven with the strobe fall until one cycle after
            // the strobes rise, giving hold from the ending edge
            mem_data_oe <= (state_q == ASRAM_WR) || (state_q == ASRAM_WR_END);
        end
    end

    // ------------------------------------------------------------
    // read response
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rsp_valid <= 1'h0;
            rsp_rdata <= '0;
        end
        else
        begin
            rsp_valid <= (state_q == ASRAM_RD) && tmr_done;
            if (state_q == ASRAM_RD && tmr_done)
            begin
                rsp_rdata <= {lane_q[HI_LANE] ? din_s2_q[DATA_W-1:BYTE_W] : {BYTE_W{1'h0}},
                    lane_q[LO_LANE] ? din_s2_q[BYTE_W-1:0] : {BYTE_W{1'h0}}};
            end
        end
    end
endmodule

// *** hw/asram_pkg.sv ***
package asram_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int LANES = 2;
    localparam int LO_LANE = 0;
    localparam int HI_LANE = 1;

    // ------------------------------------------------------------
    // timing in ns (slowest speed grade) and clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_RC_NS = 70;
    localparam int T_AA_NS = 70;
    localparam int T_PWE_NS = 50;
    localparam int T_BW_NS = 60;
    localparam int T_SCE_NS = 60;
    localparam int T_HZWE_NS = 25;
    localparam int T_HZOE_NS = 25;

    function automatic int ns_min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // write pulse must cover the longest of the strobe widths
    localparam int WR_PULSE_NS = (T_BW_NS > T_SCE_NS) ? T_BW_NS : T_SCE_NS;
    localparam int RD_CYC = ns_min_cycles(T_AA_NS > T_RC_NS ? T_AA_NS : T_RC_NS);
    localparam int WR_CYC = ns_min_cycles(WR_PULSE_NS > T_PWE_NS ? WR_PULSE_NS : T_PWE_NS);
    localparam int TURN_CYC = ns_min_cycles(T_HZWE_NS > T_HZOE_NS ? T_HZWE_NS : T_HZOE_NS);
    localparam int CNT_W = 4;
endpackage
